/* rtl/tecu_pkg.sv */
// shared constants and carrier types of the timer event capture unit
package tecu_pkg;

	// ---------------------------------------------------------------
	// register map (byte offsets inside one channel window)
	// ---------------------------------------------------------------
	localparam int unsigned  TECU_NCH          = 4;
	localparam int unsigned  TECU_ADDR_W       = 7;
	localparam logic [4:0]   TECU_OFS_CTRL     = 5'h00;
	localparam logic [4:0]   TECU_OFS_CMP      = 5'h04;
	localparam logic [4:0]   TECU_OFS_MFLAG    = 5'h08;
	localparam logic [4:0]   TECU_OFS_COUNT    = 5'h0c;
	localparam logic [4:0]   TECU_OFS_CAPT     = 5'h10;
	localparam logic [4:0]   TECU_OFS_TRIG     = 5'h14;
	localparam logic [4:0]   TECU_OFS_EFLAG    = 5'h18;

	// ---------------------------------------------------------------
	// channel_control_reg fields
	// ---------------------------------------------------------------
	localparam int unsigned  TECU_RUN_BIT      = 30;
	localparam int unsigned  TECU_IRQ_BIT      = 29;
	localparam int unsigned  TECU_MODE_LSB     = 27;
	localparam int unsigned  TECU_EVSEL_BIT    = 24;
	localparam int unsigned  TECU_WAKE_BIT     = 23;
	localparam int unsigned  TECU_PSC_LSB      = 0;
	localparam logic [7:0]   TECU_PSC_RST      = 8'h05;

	// ---------------------------------------------------------------
	// trigger_control_reg fields
	// ---------------------------------------------------------------
	localparam int unsigned  TECU_PHASE_BIT    = 0;
	localparam int unsigned  TECU_EDGE_LSB     = 1;
	localparam int unsigned  TECU_TEN_BIT      = 3;
	localparam int unsigned  TECU_ACT_BIT      = 4;
	localparam int unsigned  TECU_TDB_BIT      = 6;
	localparam int unsigned  TECU_EDB_BIT      = 7;

	// ---------------------------------------------------------------
	// counting modes and edge selections
	// ---------------------------------------------------------------
	localparam logic [1:0]   TECU_ONE_SHOT     = 2'h0;
	localparam logic [1:0]   TECU_PERIODIC     = 2'h1;
	localparam logic [1:0]   TECU_TOGGLE       = 2'h2;
	localparam logic [1:0]   TECU_CONTINUOUS   = 2'h3;
	localparam logic [1:0]   TECU_EDGE_FALL    = 2'h0;
	localparam logic [1:0]   TECU_EDGE_RISE    = 2'h1;

	// samples a de-bounced pin must hold before it is believed
	localparam logic [1:0]   TECU_DBNC_SAMPLES = 2'h3;

	typedef struct packed {
		logic       run_enable_bit;
		logic       irq_allow_bit;
		logic [1:0] mode;
		logic       event_count_select;
		logic       wake_enable;
		logic [7:0] prescale;
	} tecu_ctrl_t;

	typedef struct packed {
		logic       event_pin_debounce_on;
		logic       trigger_pin_debounce_on;
		logic       trigger_action_select;
		logic       trigger_enable;
		logic [1:0] trigger_edge_select;
		logic       event_phase;
	} tecu_trig_t;

endpackage : tecu_pkg

/* rtl/tecu_timer.sv */
// four timer channels with prescaler, compare, event counting and capture
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

// How it works
// (R01) four channels, each an 8-bit prescaler feeding a 24-bit up counter
// (R02) interval is tick period times prescale plus one times compare value
// (R03) mode field picks one-shot, periodic, toggle or continuous; run bit starts
// (R04) one-shot match sets flag, clears counter and run bit
// (R05) interrupt request is match flag and interrupt allow bit
// (R06) periodic match sets flag, clears counter, keeps counting
// (R07) toggle mode counts as periodic and inverts the pin per match
// (R08) continuous match keeps counting and wraps from maximum to zero
// (R09) compare value may be rewritten while continuous counting runs
// (R10) selected edge on the trigger pin sets the external event flag
// (R11) reading the counter register returns the live counter
// (R12) event select bit makes event pin edges drive the counter
// (R13) event pin has a de-bounce enable; event rate kept low by others
// (R14) event phase bit picks which event pin edge counts
// (R15) event counting works with one-shot, periodic and continuous compare
// (R16) action bit zero: trigger edge copies counter into capture register
// (R17) trigger pin has a de-bounce enable; trigger rate kept low by others
// (R18) edge select field picks which trigger transitions are detected
// (R19) capture happens whatever the counting mode
// (R20) action bit one: trigger edge clears the counter instead
// (R21) an interrupt while the chip sleeps raises a wake-up request
// (R22) each channel counts on its own timer tick input
// (R23) restarting after a stop resumes from the held counter value
// (R24) counters and flags are zero after reset and nothing counts
// (R25) software clears the match flag after servicing it
module tecu_timer
	import tecu_pkg::*;
#(
	parameter int unsigned NCH = TECU_NCH
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	input  wire logic [TECU_ADDR_W-1:0] avs_address_i,
	input  wire logic                   avs_read_i,
	input  wire logic                   avs_write_i,
	input  wire logic [31:0]            avs_writedata_i,
	input  wire logic [3:0]             avs_byteenable_i,
	output logic      [31:0]            avs_readdata_o,
	output logic                        avs_waitrequest_o,
	input  wire logic [NCH-1:0]         timer_tick_i,
	input  wire logic [NCH-1:0]         event_toggle_pin_i,
	output logic      [NCH-1:0]         event_toggle_pin_o,
	output logic      [NCH-1:0]         event_toggle_pin_oe_o,
	input  wire logic [NCH-1:0]         capture_trigger_pin_i,
	input  wire logic                   chip_asleep_i,
	output logic      [NCH-1:0]         irq_o,
	output logic                        wake_req_o
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : be_merge

	function automatic logic [31:0] ctrl_image(input tecu_ctrl_t c);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[TECU_RUN_BIT] = c.run_enable_bit;
		v[TECU_IRQ_BIT] = c.irq_allow_bit;
		v[TECU_MODE_LSB +: 2] = c.mode;
		v[TECU_EVSEL_BIT] = c.event_count_select;
		v[TECU_WAKE_BIT] = c.wake_enable;
		v[TECU_PSC_LSB +: 8] = c.prescale;
		return v;
	endfunction : ctrl_image

	function automatic logic [31:0] trig_image(input tecu_trig_t t);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[TECU_PHASE_BIT] = t.event_phase;
		v[TECU_EDGE_LSB +: 2] = t.trigger_edge_select;
		v[TECU_TEN_BIT] = t.trigger_enable;
		v[TECU_ACT_BIT] = t.trigger_action_select;
		v[TECU_TDB_BIT] = t.trigger_pin_debounce_on;
		v[TECU_EDB_BIT] = t.event_pin_debounce_on;
		return v;
	endfunction : trig_image

	// ---------------------------------------------------------------
	// per channel state
	// ---------------------------------------------------------------
	tecu_ctrl_t  ctrl          [NCH];
	tecu_trig_t  trig          [NCH];
	logic [23:0] compare_value [NCH];
	logic [23:0] counter_value [NCH];
	logic [23:0] captured_count[NCH];
	logic [7:0]  psc_cnt       [NCH];
	logic [NCH-1:0] compare_match_flag;
	logic [NCH-1:0] ext_event_flag;
	logic [NCH-1:0] toggle_q, wake_bits;

	logic [1:0]  sel_ch;
	logic [4:0]  sel_ofs;
	logic        rd_ack;
	logic [31:0] next_rdata;

	assign sel_ch  = avs_address_i[6:5];
	assign sel_ofs = avs_address_i[4:0];

	// ---------------------------------------------------------------
	// avalon slave: writes land at once, reads take one wait cycle
	// ---------------------------------------------------------------
	assign avs_waitrequest_o = avs_read_i & ~rd_ack;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (sel_ofs)
			TECU_OFS_CTRL:  next_rdata = ctrl_image(ctrl[sel_ch]);
			TECU_OFS_CMP:   next_rdata = {8'h00, compare_value[sel_ch]};
			TECU_OFS_MFLAG: next_rdata = {31'h0, compare_match_flag[sel_ch]};
			TECU_OFS_COUNT: next_rdata = {8'h00, counter_value[sel_ch]}; // [R11]
			TECU_OFS_CAPT:  next_rdata = {8'h00, captured_count[sel_ch]};
			TECU_OFS_TRIG:  next_rdata = trig_image(trig[sel_ch]);
			TECU_OFS_EFLAG: next_rdata = {31'h0, ext_event_flag[sel_ch]};
			default:        next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ack         <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			rd_ack <= avs_read_i & ~rd_ack;
			if (avs_read_i & ~rd_ack) begin
				avs_readdata_o <= next_rdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic        wr_hit;
		logic [31:0] ctrl_new;
		logic [31:0] trig_new;
		logic [31:0] cmp_new;
		logic        ev_s1, ev_s2, ev_f, ev_d;
		logic        tr_s1, tr_s2, tr_f, tr_d;
		logic [1:0]  ev_cnt, tr_cnt;
		logic        ev_edge, tr_rise, tr_fall, tr_hit;
		logic        tick, inc, match;
		logic [23:0] next_count;

		assign wr_hit   = avs_write_i && (sel_ch == 2'(i));
		assign ctrl_new = be_merge(ctrl_image(ctrl[i]), avs_writedata_i, avs_byteenable_i);
		assign trig_new = be_merge(trig_image(trig[i]), avs_writedata_i, avs_byteenable_i);
		assign cmp_new  = be_merge({8'h00, compare_value[i]}, avs_writedata_i, avs_byteenable_i);

		// pins come from outside: two flops, then an optional hold filter
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				ev_s1 <= 1'b0;
				ev_s2 <= 1'b0;
				tr_s1 <= 1'b0;
				tr_s2 <= 1'b0;
			end else begin
				ev_s1 <= event_toggle_pin_i[i];
				ev_s2 <= ev_s1;
				tr_s1 <= capture_trigger_pin_i[i];
				tr_s2 <= tr_s1;
			end
		end

		// filter trades two cycles of latency for rejecting short glitches
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				ev_cnt <= 2'h0;
				ev_f   <= 1'b0;
				ev_d   <= 1'b0;
				tr_cnt <= 2'h0;
				tr_f   <= 1'b0;
				tr_d   <= 1'b0;
			end else begin
				ev_d <= ev_f;
				tr_d <= tr_f;
				if (!trig[i].event_pin_debounce_on || ev_s2 == ev_f) begin // [R13]
					ev_cnt <= 2'h0;
					if (!trig[i].event_pin_debounce_on) begin
						ev_f <= ev_s2;
					end
				end else if (ev_cnt == TECU_DBNC_SAMPLES - 2'h1) begin
					ev_cnt <= 2'h0;
					ev_f   <= ev_s2;
				end else begin
					ev_cnt <= ev_cnt + 2'h1;
				end
				if (!trig[i].trigger_pin_debounce_on || tr_s2 == tr_f) begin // [R17]
					tr_cnt <= 2'h0;
					if (!trig[i].trigger_pin_debounce_on) begin
						tr_f <= tr_s2;
					end
				end else if (tr_cnt == TECU_DBNC_SAMPLES - 2'h1) begin
					tr_cnt <= 2'h0;
					tr_f   <= tr_s2;
				end else begin
					tr_cnt <= tr_cnt + 2'h1;
				end
			end
		end

		assign ev_edge = trig[i].event_phase ? (ev_f & ~ev_d) : (~ev_f & ev_d); // [R14]
		assign tr_rise = tr_f & ~tr_d;
		assign tr_fall = ~tr_f & tr_d;
		always_comb begin
			case (trig[i].trigger_edge_select) // [R18]
				TECU_EDGE_FALL: tr_hit = tr_fall;
				TECU_EDGE_RISE: tr_hit = tr_rise;
				default:        tr_hit = tr_rise | tr_fall;
			endcase
			tr_hit = tr_hit & trig[i].trigger_enable;
		end

		// event pin edges replace the channel tick when event select is set
		assign tick = ctrl[i].event_count_select ? ev_edge : timer_tick_i[i]; // [R12] [R22]
		assign inc  = ctrl[i].run_enable_bit && tick
			&& (ctrl[i].event_count_select || psc_cnt[i] == ctrl[i].prescale); // [R02]
		assign next_count = counter_value[i] + 24'h1;
		assign match = inc && (next_count == compare_value[i]); // [R15]

		// prescaler and control register
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				psc_cnt[i] <= 8'h00; // [R24]
				ctrl[i]    <= '{prescale: TECU_PSC_RST, default: '0};
			end else begin
				if (ctrl[i].run_enable_bit && tick && !ctrl[i].event_count_select) begin // [R01]
					psc_cnt[i] <= (psc_cnt[i] == ctrl[i].prescale) ? 8'h00 : psc_cnt[i] + 8'h01;
				end
				if (wr_hit && sel_ofs == TECU_OFS_CTRL) begin // [R03]
					ctrl[i].run_enable_bit     <= ctrl_new[TECU_RUN_BIT];
					ctrl[i].irq_allow_bit      <= ctrl_new[TECU_IRQ_BIT];
					ctrl[i].mode               <= ctrl_new[TECU_MODE_LSB +: 2];
					ctrl[i].event_count_select <= ctrl_new[TECU_EVSEL_BIT];
					ctrl[i].wake_enable        <= ctrl_new[TECU_WAKE_BIT];
					ctrl[i].prescale           <= ctrl_new[TECU_PSC_LSB +: 8];
				end
				if (match && ctrl[i].mode == TECU_ONE_SHOT) begin
					ctrl[i].run_enable_bit <= 1'b0; // [R04]
				end
			end
		end

		// counter, compare and capture
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				counter_value[i]  <= 24'h000000; // [R24]
				compare_value[i]  <= 24'h000000;
				captured_count[i] <= 24'h000000;
			end else begin
				if (wr_hit && sel_ofs == TECU_OFS_CMP) begin
					compare_value[i] <= cmp_new[23:0]; // [R09]
				end
				if (tr_hit && !trig[i].trigger_action_select) begin
					captured_count[i] <= counter_value[i]; // [R16] [R19]
				end
				if (tr_hit && trig[i].trigger_action_select) begin
					counter_value[i] <= 24'h000000; // [R20]
				end else if (match && ctrl[i].mode != TECU_CONTINUOUS) begin
					counter_value[i] <= 24'h000000; // [R04] [R06]
				end else if (inc) begin
					counter_value[i] <= next_count; // [R08] [R23]
				end
			end
		end

		// flags: a set in the same cycle as a clear wins
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				compare_match_flag[i] <= 1'b0;
				ext_event_flag[i]     <= 1'b0;
				trig[i]               <= '0;
			end else begin
				if (match) begin
					compare_match_flag[i] <= 1'b1; // [R04] [R06] [R08]
				end else if (wr_hit && sel_ofs == TECU_OFS_MFLAG && avs_byteenable_i[0]
					&& avs_writedata_i[0]) begin
					compare_match_flag[i] <= 1'b0; // [R25]
				end
				if (tr_hit) begin
					ext_event_flag[i] <= 1'b1; // [R10]
				end else if (wr_hit && sel_ofs == TECU_OFS_EFLAG && avs_byteenable_i[0]
					&& avs_writedata_i[0]) begin
					ext_event_flag[i] <= 1'b0;
				end
				if (wr_hit && sel_ofs == TECU_OFS_TRIG) begin
					trig[i].event_phase             <= trig_new[TECU_PHASE_BIT];
					trig[i].trigger_edge_select     <= trig_new[TECU_EDGE_LSB +: 2];
					trig[i].trigger_enable          <= trig_new[TECU_TEN_BIT];
					trig[i].trigger_action_select   <= trig_new[TECU_ACT_BIT];
					trig[i].trigger_pin_debounce_on <= trig_new[TECU_TDB_BIT];
					trig[i].event_pin_debounce_on   <= trig_new[TECU_EDB_BIT];
				end
			end
		end

		// toggle output: one inversion per match gives an even square wave
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				toggle_q[i] <= 1'b0;
			end else if (match && ctrl[i].mode == TECU_TOGGLE) begin
				toggle_q[i] <= ~toggle_q[i]; // [R07]
			end
		end

		assign event_toggle_pin_o[i]    = toggle_q[i];
		assign event_toggle_pin_oe_o[i] = (ctrl[i].mode == TECU_TOGGLE);
		assign irq_o[i] = compare_match_flag[i] & ctrl[i].irq_allow_bit; // [R05]
		assign wake_bits[i] = ctrl[i].wake_enable;

		// -----------------------------------------------------------
		// checks
		// -----------------------------------------------------------
		chk_oneshot_stop: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R04]
			match && ctrl[i].mode == TECU_ONE_SHOT && !tr_hit
			|=> !ctrl[i].run_enable_bit && counter_value[i] == 24'h0 && compare_match_flag[i])
			else $error("one-shot match did not stop and clear");
		chk_periodic_go: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R06]
			match && ctrl[i].mode == TECU_PERIODIC && !(wr_hit && sel_ofs == TECU_OFS_CTRL)
			|=> ctrl[i].run_enable_bit && counter_value[i] == 24'h0)
			else $error("periodic match did not restart");
		chk_irq_follow: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R05]
			match && ctrl[i].irq_allow_bit && !(wr_hit && sel_ofs == TECU_OFS_CTRL)
			|=> irq_o[i])
			else $error("no interrupt after match");
		chk_toggle_flip: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R07]
			match && ctrl[i].mode == TECU_TOGGLE
			|=> event_toggle_pin_o[i] != $past(event_toggle_pin_o[i]))
			else $error("toggle pin did not invert");
		chk_cont_keep: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R08]
			inc && ctrl[i].mode == TECU_CONTINUOUS && !tr_hit
			|=> counter_value[i] == $past(counter_value[i]) + 24'h1)
			else $error("continuous counter did not advance or wrap");
		chk_capture_copy: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R16]
			tr_hit && !trig[i].trigger_action_select
			|=> captured_count[i] == $past(counter_value[i]) && ext_event_flag[i])
			else $error("capture missed the counter");
		chk_trig_reset: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R20]
			tr_hit && trig[i].trigger_action_select |=> counter_value[i] == 24'h0)
			else $error("trigger did not reset counter");
		chk_stop_hold: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R23]
			!ctrl[i].run_enable_bit && !tr_hit |=> $stable(counter_value[i]))
			else $error("counter moved while stopped");
		chk_psc_gate: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R02]
			inc && !ctrl[i].event_count_select |-> psc_cnt[i] == ctrl[i].prescale
			##1 psc_cnt[i] == 8'h00)
			else $error("count advanced off the prescale boundary");
	end
	assign wake_req_o = chip_asleep_i && |(irq_o & wake_bits); // [R21]
	chk_wake_req: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R21]
		chip_asleep_i && (irq_o[0] && ctrl[0].wake_enable) |-> wake_req_o)
		else $error("no wake-up request while asleep");

endmodule : tecu_timer

/* verification/tecu_pin_model.sv */
// pin-side partner: shapes event and capture trigger pulses for the timer channels
`timescale 1ns/1ps

module tecu_pin_model (
	input  wire logic       core_clk_i,
	input  wire logic [3:0] ev_go_i,
	input  wire logic [3:0] trig_go_i,
	output logic      [3:0] event_pin_o,
	output logic      [3:0] trigger_pin_o
);
	// ---------------------------------------------------------------
	// pulse shaping
	// ---------------------------------------------------------------
	// each request gives 8 high then 8 low cycles, so edges stay under 1/8 of the
	// bus clock and a de-bounced pin still sees a stable level
	logic [3:0][4:0] ev_cnt = '0;
	logic [3:0][4:0] tr_cnt = '0;

	always @(posedge core_clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (ev_go_i[i] && ev_cnt[i] == 5'h00) ev_cnt[i] <= 5'h10;
			else if (ev_cnt[i] != 5'h00) ev_cnt[i] <= ev_cnt[i] - 5'h01;
			if (trig_go_i[i] && tr_cnt[i] == 5'h00) tr_cnt[i] <= 5'h10;
			else if (tr_cnt[i] != 5'h00) tr_cnt[i] <= tr_cnt[i] - 5'h01;
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			event_pin_o[i]   = ev_cnt[i] > 5'h08;
			trigger_pin_o[i] = tr_cnt[i] > 5'h08;
		end
	end
endmodule : tecu_pin_model

/* verification/tb.sv */
// self-checking bench for the timer event capture unit
`timescale 1ns/1ps

module tb import tecu_pkg::*;;
	logic        core_clk_i        = 1'b0;
	logic        rst_i             = 1'b1;
	logic [6:0]  avs_address_i     = 7'h00;
	logic        avs_read_i        = 1'b0;
	logic        avs_write_i       = 1'b0;
	logic [31:0] avs_writedata_i   = 32'h0;
	logic [3:0]  avs_byteenable_i  = 4'hf;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [3:0]  timer_tick_i      = 4'hf;
	logic [3:0]  ev_pin_w;
	logic [3:0]  model_ev;
	logic [3:0]  event_toggle_pin_o;
	logic [3:0]  event_toggle_pin_oe_o;
	logic [3:0]  capture_trigger_pin_i;
	logic        chip_asleep_i     = 1'b0;
	logic [3:0]  irq_o;
	logic        wake_req_o;
	logic [3:0]  ev_go             = 4'h0;
	logic [3:0]  trig_go           = 4'h0;
	logic [31:0] q, a, b;
	int          n_fail            = 0;
	int          checks_done       = 0;

	// the toggle pin is shared: the channel wins while it drives
	assign ev_pin_w = (event_toggle_pin_oe_o & event_toggle_pin_o)
		| (~event_toggle_pin_oe_o & model_ev);

	tecu_timer tecu_timer_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .timer_tick_i(timer_tick_i),
		.event_toggle_pin_i(ev_pin_w), .event_toggle_pin_o(event_toggle_pin_o),
		.event_toggle_pin_oe_o(event_toggle_pin_oe_o), .capture_trigger_pin_i(capture_trigger_pin_i),
		.chip_asleep_i(chip_asleep_i), .irq_o(irq_o), .wake_req_o(wake_req_o));

	tecu_pin_model tecu_pin_model_i (.core_clk_i(core_clk_i), .ev_go_i(ev_go), .trig_go_i(trig_go),
		.event_pin_o(model_ev), .trigger_pin_o(capture_trigger_pin_i));

	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk32

	task automatic chk1(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk1

	task automatic timeout();
		n_fail++;
		$display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		finish_test();
	endtask : timeout

	// request held until waitrequest is seen low; one idle edge follows the release
	task automatic bus(input logic wr, input logic [1:0] ch, input logic [4:0] ofs,
		input logic [31:0] d, output logic [31:0] rdata);
		int n;
		avs_address_i   <= {ch, ofs};
		avs_writedata_i <= d;
		avs_write_i     <= wr;
		avs_read_i      <= !wr;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 100);
		rdata = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
		@(posedge core_clk_i);
		if (n >= 100) timeout();
	endtask : bus

	task automatic wr(input logic [1:0] ch, input logic [4:0] ofs, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, ch, ofs, d, dummy);
	endtask : wr

	task automatic rd(input logic [1:0] ch, input logic [4:0] ofs, output logic [31:0] r);
		bus(1'b0, ch, ofs, 32'h0, r);
	endtask : rd

	function automatic logic [31:0] ctl(logic run, logic ie, logic [1:0] mode, logic ev,
		logic wk, logic [7:0] psc);
		ctl = 32'h0;
		ctl[TECU_RUN_BIT]           = run;
		ctl[TECU_IRQ_BIT]           = ie;
		ctl[TECU_MODE_LSB +: 2]     = mode;
		ctl[TECU_EVSEL_BIT]         = ev;
		ctl[TECU_WAKE_BIT]          = wk;
		ctl[TECU_PSC_LSB +: 8]      = psc;
	endfunction : ctl

	task automatic wait_irq(input int ch);
		int n;
		n = 0;
		while (irq_o[ch] !== 1'b1 && n < 3000) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 3000) timeout();
	endtask : wait_irq

	task automatic pulse(input logic ev, input int ch);
		if (ev) ev_go[ch] <= 1'b1;
		else trig_go[ch] <= 1'b1;
		@(posedge core_clk_i);
		ev_go   <= 4'h0;
		trig_go <= 4'h0;
		repeat (24) @(posedge core_clk_i);
	endtask : pulse

	task automatic wait_change(output int n);
		logic p;
		p = event_toggle_pin_o[1];
		n = 0;
		while (event_toggle_pin_o[1] === p && n < 500) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 500) timeout();
	endtask : wait_change

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rd(0, TECU_OFS_CTRL, q);  chk32(q, 32'h0000_0005);
		rd(1, TECU_OFS_COUNT, q); chk32(q, 32'h0);
		rd(2, TECU_OFS_MFLAG, q); chk32(q, 32'h0);
		rd(3, TECU_OFS_EFLAG, q); chk32(q, 32'h0);
		wr(0, TECU_OFS_COUNT, 32'h0000_1234);
		rd(0, TECU_OFS_COUNT, q); chk32(q, 32'h0);
		rd(0, 5'h1c, q);          chk32(q, 32'h0);
		chk1(irq_o[0], 1'b0);
		$display("reset values done");
	endtask : t_reset

	task automatic t_oneshot();
		chip_asleep_i <= 1'b1;
		wr(0, TECU_OFS_CMP, 32'h4);
		wr(0, TECU_OFS_CTRL, ctl(1, 1, TECU_ONE_SHOT, 0, 1, 8'h00));
		wait_irq(0);
		chk1(wake_req_o, 1'b1);
		rd(0, TECU_OFS_CTRL, q);  chk1(q[TECU_RUN_BIT], 1'b0);
		rd(0, TECU_OFS_MFLAG, q); chk32(q, 32'h1);
		repeat (10) @(posedge core_clk_i);
		rd(0, TECU_OFS_COUNT, q); chk32(q, 32'h0);
		wr(0, TECU_OFS_MFLAG, 32'h1);
		chk1(irq_o[0], 1'b0);
		chip_asleep_i <= 1'b0;
		$display("one-shot done");
	endtask : t_oneshot

	task automatic t_periodic();
		wr(0, TECU_OFS_CMP, 32'h5);
		wr(0, TECU_OFS_CTRL, ctl(1, 1, TECU_PERIODIC, 0, 0, 8'h00));
		wait_irq(0);
		rd(0, TECU_OFS_CTRL, q);  chk1(q[TECU_RUN_BIT], 1'b1);
		rd(0, TECU_OFS_COUNT, q); chk1(q[23:0] < 24'h5, 1'b1);
		wr(0, TECU_OFS_CTRL, ctl(0, 1, TECU_PERIODIC, 0, 0, 8'h00));
		wr(0, TECU_OFS_MFLAG, 32'h1);
		chk1(irq_o[0], 1'b0);
		$display("periodic done");
	endtask : t_periodic

	task automatic t_toggle();
		int n;
		wr(1, TECU_OFS_CMP, 32'h4);
		wr(1, TECU_OFS_CTRL, ctl(1, 0, TECU_TOGGLE, 0, 0, 8'h02));
		chk1(event_toggle_pin_oe_o[1], 1'b1);
		wait_change(n);
		wait_change(n); chk32(32'(n), 32'd12);
		wait_change(n); chk32(32'(n), 32'd12);
		wr(1, TECU_OFS_CTRL, 32'h0);
		$display("toggle done");
	endtask : t_toggle

	task automatic t_cont();
		wr(2, TECU_OFS_CMP, 32'h3);
		wr(2, TECU_OFS_CTRL, ctl(1, 1, TECU_CONTINUOUS, 0, 0, 8'h00));
		wait_irq(2);
		rd(2, TECU_OFS_COUNT, q); chk1(q[23:0] > 24'h3, 1'b1);
		wr(2, TECU_OFS_CMP, 32'h40);
		wr(2, TECU_OFS_MFLAG, 32'h1);
		wait_irq(2);
		rd(2, TECU_OFS_COUNT, q); chk1(q[23:0] >= 24'h40 && q[23:0] <= 24'h46, 1'b1);
		wr(2, TECU_OFS_CTRL, ctl(0, 1, TECU_CONTINUOUS, 0, 0, 8'h00));
		rd(2, TECU_OFS_COUNT, a);
		repeat (10) @(posedge core_clk_i);
		rd(2, TECU_OFS_COUNT, q); chk32(q, a);
		wr(2, TECU_OFS_CTRL, ctl(1, 0, TECU_CONTINUOUS, 0, 0, 8'h00));
		repeat (10) @(posedge core_clk_i);
		rd(2, TECU_OFS_COUNT, q); chk1(q > a && q < a + 32'd32, 1'b1);
		wr(2, TECU_OFS_CTRL, 32'h0);
		$display("continuous done");
	endtask : t_cont

	task automatic t_event();
		wr(3, TECU_OFS_TRIG, 32'h1);
		wr(3, TECU_OFS_CMP, 32'h100);
		wr(3, TECU_OFS_CTRL, ctl(1, 0, TECU_CONTINUOUS, 1, 0, 8'h00));
		repeat (3) pulse(1'b1, 3);
		rd(3, TECU_OFS_COUNT, q); chk32(q, 32'h3);
		wr(3, TECU_OFS_TRIG, 32'h80);
		repeat (2) pulse(1'b1, 3);
		rd(3, TECU_OFS_COUNT, q); chk32(q, 32'h5);
		wr(3, TECU_OFS_CMP, 32'h6);
		pulse(1'b1, 3);
		rd(3, TECU_OFS_MFLAG, q); chk32(q, 32'h1);
		$display("event counting done");
	endtask : t_event

	task automatic t_capture();
		wr(0, TECU_OFS_CMP, 32'h3000);
		wr(0, TECU_OFS_CTRL, ctl(1, 0, TECU_PERIODIC, 0, 0, 8'h00));
		wr(0, TECU_OFS_TRIG, 32'h4a);
		repeat (100) @(posedge core_clk_i);
		pulse(1'b0, 0);
		rd(0, TECU_OFS_CAPT, a);
		rd(0, TECU_OFS_COUNT, b); chk1(a > 32'd100 && a < b, 1'b1);
		rd(0, TECU_OFS_EFLAG, q); chk32(q, 32'h1);
		wr(0, TECU_OFS_EFLAG, 32'h1);
		rd(0, TECU_OFS_EFLAG, q); chk32(q, 32'h0);
		wr(0, TECU_OFS_TRIG, 32'h5a);
		pulse(1'b0, 0);
		rd(0, TECU_OFS_COUNT, q); chk1(q < 32'd40, 1'b1);
		rd(0, TECU_OFS_CAPT, q);  chk32(q, a);
		wr(0, TECU_OFS_TRIG, 32'h48);
		pulse(1'b0, 0);
		rd(0, TECU_OFS_CAPT, q);  chk1(q != a, 1'b1);
		timer_tick_i <= 4'he;
		rd(0, TECU_OFS_COUNT, a);
		repeat (5) @(posedge core_clk_i);
		rd(0, TECU_OFS_COUNT, q); chk32(q, a);
		timer_tick_i <= 4'hf;
		$display("capture and reset done");
	endtask : t_capture

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		t_reset();
		t_oneshot();
		t_periodic();
		t_toggle();
		t_cont();
		t_event();
		t_capture();
		finish_test();
	end
endmodule : tb
